// >>> pkg/sbd_pkg.sv
`default_nettype none
package sbd_pkg;
	// ------------------------------------------------------------
	// Widths and field positions of the shared bus
	// ------------------------------------------------------------
	localparam int SBD_BUS_W = 16;
	localparam int SBD_ADDR_W = 11;
	localparam int SBD_BE_W = 4;
	localparam int SBD_BE_LSB = 12;
	localparam int SBD_A16_LSB = 2;
	localparam int SBD_A16_MSB = 10;
	localparam int SBD_A8_HI_LSB = 8;
	localparam logic [10:0] SBD_ADDR_RST = 11'h000;
	localparam logic [3:0] SBD_BE_RST = 4'h0;
	localparam logic [15:0] SBD_DATA_RST = 16'h0000;

	// Write sequencing for the 8-bit address pair
	typedef enum logic {
		SBD_ADDR_LOW,
		SBD_ADDR_HIGH
	} sbd_phase_t;

	// Decoded access handed to the core
	typedef struct packed {
		logic [10:0] addr;
		logic [3:0] byte_en;
		logic [15:0] data;
	} sbd_access_t;
endpackage : sbd_pkg
`default_nettype wire

// >>> src/sbd_demux.sv
`timescale 1ns/100ps
`default_nettype none

module sbd_demux
	import sbd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic bus16_mode,
	input wire logic device_select_n,
	input wire logic write_n,
	input wire logic addr_data_sel,
	input wire logic [15:0] shared_bus_line,
	output logic [10:0] addr,
	output logic [3:0] byte_lane_enable,
	output logic [15:0] wr_data,
	output logic wr_data_valid,
	output logic addr_valid
);
	// ------------------------------------------------------------
	// Write strobe edge detection
	// ------------------------------------------------------------
	logic write_n_q;
	logic wr_take;
	// Strobes are treated as synchronous; capture on the falling edge of write
	// Needing a high sample first means a strobe held low for many cycles is taken once only
	assign wr_take = !device_select_n && !write_n && write_n_q;

	// ------------------------------------------------------------
	// Decode state
	// ------------------------------------------------------------
	sbd_phase_t phase, next_phase;
	logic [10:0] next_addr;
	logic [3:0] next_be;
	logic [15:0] next_data;
	logic next_data_valid, next_addr_valid;

	// Next-value computation for address, enables, data and phase
	always_comb begin
		next_phase = phase;
		next_addr = addr;
		next_be = byte_lane_enable;
		next_data = wr_data;
		next_data_valid = 1'b0;
		next_addr_valid = 1'b0;
		if (wr_take) begin
			if (!addr_data_sel) begin
				if (bus16_mode) begin
					next_data = shared_bus_line;
				end else begin
					// Upper lines are tied low in byte mode, never trust them
					next_data = {8'h00, shared_bus_line[7:0]};
				end
				next_data_valid = 1'b1;
			end else if (bus16_mode) begin
				// Line 11 and lines 1..0 are dropped here
				next_be = shared_bus_line[15:SBD_BE_LSB];
				next_addr = {shared_bus_line[SBD_A16_MSB:SBD_A16_LSB], 2'b00};
				next_phase = SBD_ADDR_LOW;
				next_addr_valid = 1'b1;
			end else if (phase == SBD_ADDR_LOW) begin
				next_addr = {addr[10:8], shared_bus_line[7:0]};
				next_phase = SBD_ADDR_HIGH;
			end else begin
				next_addr = {shared_bus_line[2:0], addr[7:0]};
				next_phase = SBD_ADDR_LOW;
				next_addr_valid = 1'b1;
			end
		end
	end

	// Registers only; outputs stay flop-driven
	always_ff @(posedge clk) begin
		if (reset) begin
			// Edge detector starts at the idle level, so a selected strobe already low as reset lifts is taken at once
			write_n_q <= 1'b1;
			phase <= SBD_ADDR_LOW;
			addr <= SBD_ADDR_RST;
			byte_lane_enable <= SBD_BE_RST;
			wr_data <= SBD_DATA_RST;
			wr_data_valid <= 1'b0;
			addr_valid <= 1'b0;
		end else begin
			write_n_q <= write_n;
			phase <= next_phase;
			addr <= next_addr;
			byte_lane_enable <= next_be;
			wr_data <= next_data;
			wr_data_valid <= next_data_valid;
			addr_valid <= next_addr_valid;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_data16;
		@(posedge clk) disable iff (reset)
		(wr_take && !addr_data_sel && bus16_mode) |=> (wr_data == $past(shared_bus_line)) && wr_data_valid;
	endproperty
	a_data16: assert property (p_data16) else $error("16-bit data not taken");

	property p_be;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && bus16_mode) |=> byte_lane_enable == $past(shared_bus_line[15:12]);
	endproperty
	a_be: assert property (p_be) else $error("byte enables wrong");

	property p_a16;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && bus16_mode) |=> addr == {$past(shared_bus_line[10:2]), 2'b00} && addr_valid;
	endproperty
	a_a16: assert property (p_a16) else $error("16-bit address wrong");

	property p_data8;
		@(posedge clk) disable iff (reset)
		(wr_take && !addr_data_sel && !bus16_mode) |=> wr_data[15:8] == 8'h00;
	endproperty
	a_data8: assert property (p_data8) else $error("upper lines used in 8-bit mode");

	property p_lo8;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && !bus16_mode && phase == SBD_ADDR_LOW)
			|=> addr[7:0] == $past(shared_bus_line[7:0]) && !addr_valid;
	endproperty
	a_lo8: assert property (p_lo8) else $error("low address byte wrong");

	property p_hi8;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && !bus16_mode && phase == SBD_ADDR_HIGH)
			|=> addr[10:8] == $past(shared_bus_line[2:0]) && addr[7:0] == $past(addr[7:0]) && addr_valid;
	endproperty
	a_hi8: assert property (p_hi8) else $error("high address bits wrong");

	property p_hold;
		@(posedge clk) disable iff (reset)
		(!wr_take || !addr_data_sel) |=> $stable(addr) && $stable(byte_lane_enable);
	endproperty
	a_hold: assert property (p_hold) else $error("latched address changed");

	property p_sel;
		@(posedge clk) disable iff (reset)
		device_select_n |=> !wr_data_valid && !addr_valid;
	endproperty
	a_sel: assert property (p_sel) else $error("access without select");

	// ------------------------------------------------------------
	// Pulse, hold, reset and bit-placement checks
	// ------------------------------------------------------------
	// Reset clears every output and rearms the byte-mode pair
	property p_rst;
		@(posedge clk)
		reset |=> addr == SBD_ADDR_RST && byte_lane_enable == SBD_BE_RST && wr_data == SBD_DATA_RST
			&& !wr_data_valid && !addr_valid && phase == SBD_ADDR_LOW;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");

	// A strobe held low across edges must not be taken again
	property p_once;
		@(posedge clk) disable iff (reset)
		(!write_n && !write_n_q) |=> !wr_data_valid && !addr_valid;
	endproperty
	a_once: assert property (p_once) else $error("held strobe taken twice");

	// Valid pulses last exactly one cycle
	property p_pulse;
		@(posedge clk) disable iff (reset)
		(wr_data_valid || addr_valid) |=> !wr_data_valid && !addr_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("valid pulse too long");

	// Word address leaves the two low bits clear and rearms the byte-mode pair
	property p_a16_low;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && bus16_mode) |=> addr[1:0] == 2'b00 && phase == SBD_ADDR_LOW;
	endproperty
	a_a16_low: assert property (p_a16_low) else $error("16-bit address low bits set");

	// Line 0 lands in bit 0 on the first byte-mode write and in bit 8 on the second
	property p_line0;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && !bus16_mode)
			|=> ($past(phase) == SBD_ADDR_LOW ? addr[0] == $past(shared_bus_line[0])
				: addr[8] == $past(shared_bus_line[0]));
	endproperty
	a_line0: assert property (p_line0) else $error("line 0 address bit wrong");

	// First byte-mode write keeps the upper address bits until the second arrives
	property p_lo8_keep;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && !bus16_mode && phase == SBD_ADDR_LOW) |=> addr[10:8] == $past(addr[10:8]);
	endproperty
	a_lo8_keep: assert property (p_lo8_keep) else $error("upper address bits lost");

	// Byte-mode data takes lines 7 to 0 exactly
	property p_data8_low;
		@(posedge clk) disable iff (reset)
		(wr_take && !addr_data_sel && !bus16_mode) |=> wr_data[7:0] == $past(shared_bus_line[7:0]) && wr_data_valid;
	endproperty
	a_data8_low: assert property (p_data8_low) else $error("8-bit data not taken");

	// Captured data holds until the next data write
	property p_dhold;
		@(posedge clk) disable iff (reset)
		(!wr_take || addr_data_sel) |=> $stable(wr_data);
	endproperty
	a_dhold: assert property (p_dhold) else $error("captured data changed");

	// Byte-mode address writes leave the enables alone, their lines are tied low there
	property p_be8;
		@(posedge clk) disable iff (reset)
		(wr_take && addr_data_sel && !bus16_mode) |=> $stable(byte_lane_enable);
	endproperty
	a_be8: assert property (p_be8) else $error("enables changed in 8-bit mode");
endmodule : sbd_demux

`default_nettype wire

// >>> tb/sbd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host processor writing over the shared bus
// ----------------------------------------
module sbd_host_model (
	input wire logic clk,
	output logic device_select_n,
	output logic write_n,
	output logic addr_data_sel,
	output logic [15:0] shared_bus_line
);
	// Idle with select and strobe high
	initial begin
		device_select_n = 1'b1;
		write_n = 1'b1;
		addr_data_sel = 1'b0;
		shared_bus_line = 16'h0000;
	end
	// One qualified write; the bus is inverted once released so stale values never pass
	task automatic wr(input logic sel, input logic [15:0] v);
		@(posedge clk);
		device_select_n <= 1'b0;
		write_n <= 1'b0;
		addr_data_sel <= sel;
		shared_bus_line <= v;
		repeat (2) @(posedge clk);
		device_select_n <= 1'b1;
		write_n <= 1'b1;
		shared_bus_line <= ~v;
		@(posedge clk);
	endtask : wr
	// Strobe with select left high; the device must let it pass unseen
	task automatic wr_unselected(input logic sel, input logic [15:0] v);
		@(posedge clk);
		write_n <= 1'b0;
		addr_data_sel <= sel;
		shared_bus_line <= v;
		repeat (2) @(posedge clk);
		write_n <= 1'b1;
		@(posedge clk);
	endtask : wr_unselected
endmodule : sbd_host_model
`default_nettype wire

// >>> tb/sbd_demux_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) n_checks++; if ((s) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end
module sbd_demux_bench;
	logic clk, reset, bus16_mode, sel_n, wr_n, ads, wdv, av;
	logic [15:0] bus, wr_data, got_d;
	logic [10:0] addr, got_a;
	logic [3:0] be, got_be;
	int fail_count = 0, n_checks = 0, n_av = 0, n_dv = 0, cyc = 0;
	sbd_host_model host_u (.clk(clk), .device_select_n(sel_n), .write_n(wr_n), .addr_data_sel(ads),
		.shared_bus_line(bus));
	sbd_demux dut_u (.clk(clk), .reset(reset), .bus16_mode(bus16_mode), .device_select_n(sel_n),
		.write_n(wr_n), .addr_data_sel(ads), .shared_bus_line(bus), .addr(addr), .byte_lane_enable(be),
		.wr_data(wr_data), .wr_data_valid(wdv), .addr_valid(av));
	// ----------------------------------------
	// Clock, pulse capture and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Pulses last one cycle, so results are latched here rather than polled later
	always @(posedge clk) begin
		cyc++;
		if (av === 1'b1) begin
			got_a <= addr;
			got_be <= be;
			n_av++;
		end
		if (wdv === 1'b1) begin
			got_d <= wr_data;
			n_dv++;
		end
		if (cyc == 2000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle
	// 16-bit: lines 11, 1 and 0 set but ignored, then data under the held address
	task automatic t16();
		bus16_mode <= 1'b1;
		host_u.wr(1'b1, 16'hafff);
		settle();
		`CHK("addr16", 11'h7fc, got_a)
		`CHK("be16", 4'ha, got_be)
		`CHK("av16", 1, n_av)
		host_u.wr(1'b0, 16'h9bcd);
		settle();
		`CHK("data16", 16'h9bcd, got_d)
		`CHK("dv16", 1, n_dv)
		`CHK("hold16", 11'h7fc, addr)
	endtask : t16
	// 8-bit: two address writes with junk on lines 15..8 of the first and 15..3 of the second, where they do not count
	task automatic t8();
		@(posedge clk);
		bus16_mode <= 1'b0;
		host_u.wr(1'b1, 16'hffa5);
		settle();
		`CHK("av8a", 1, n_av)
		host_u.wr(1'b1, 16'hfffd);
		settle();
		`CHK("addr8", 11'h5a5, got_a)
		`CHK("av8b", 2, n_av)
		host_u.wr(1'b0, 16'hff3c);
		settle();
		`CHK("data8", 16'h003c, got_d)
		`CHK("dv8", 2, n_dv)
		`CHK("hold8", 11'h5a5, addr)
		host_u.wr_unselected(1'b1, 16'h0002);
		settle();
		`CHK("unsel_av", 2, n_av)
		`CHK("unsel_addr", 11'h5a5, addr)
	endtask : t8
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	// Reset for four cycles, then the scenarios
	initial begin
		reset = 1'b1;
		bus16_mode = 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t16();
		t8();
		final_report();
	end
endmodule : sbd_demux_bench
`default_nettype wire
